// file: rtl/ccpsp_pkg.sv
// Package for the standard PWM unit: widths, field positions, reset values and encodings.
// Assumes a single 100 MHz system clock domain shared by all users of these names.
package ccpsp_pkg;
	localparam int unsigned TIMER_W = 8;
	localparam int unsigned DUTY_W = 10;
	localparam int unsigned SUB_W = 2;
	localparam int unsigned PRESC_W = 8;
	localparam logic [7:0] PERIOD_RST = 8'hFF;
	localparam logic [7:0] TIMER_RST = 8'h00;
	localparam logic [7:0] DUTY_REG_RST = 8'h00;
	localparam logic [9:0] DUTY_RST = 10'h000;
	localparam logic [1:0] SUB_RST = 2'h0;
	localparam logic [7:0] PRESC_RST = 8'h00;
	// Left alignment: duty_high holds bits 9:2, duty_low bits 7:6 hold bits 1:0.
	localparam int unsigned LEFT_LOW_HI = 7;
	localparam int unsigned LEFT_LOW_LO = 6;
	// Right alignment: duty_high bits 1:0 hold bits 9:8, duty_low holds bits 7:0.
	localparam int unsigned RIGHT_HIGH_HI = 1;
	localparam int unsigned RIGHT_HIGH_LO = 0;
	localparam logic [1:0] SUB_LAST = 2'h3;
	localparam logic [1:0] PS_1 = 2'h0;
	localparam logic [1:0] PS_4 = 2'h1;
	localparam logic [1:0] PS_16 = 2'h2;
	localparam logic [1:0] PS_64 = 2'h3;
	// The timer steps once per four clocks at 1:1, so an N prescale divides by 4N.
	localparam logic [7:0] PS_LAST_4 = 8'h0F;
	localparam logic [7:0] PS_LAST_16 = 8'h3F;
	localparam logic [7:0] PS_LAST_64 = 8'hFF;
	localparam int unsigned PS_SHIFT_4 = 2;
	localparam int unsigned PS_SHIFT_16 = 4;
	localparam int unsigned PS_SHIFT_64 = 6;
	typedef enum logic [0:0] {
		CCPSP_ALIGN_RIGHT = 1'b0,
		CCPSP_ALIGN_LEFT = 1'b1
	} ccpsp_align_type;
endpackage

// file: rtl/ccpsp_tb_if.sv
// Interface carrying the time base from the period timer to the main unit.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface ccpsp_tb_if;
	logic [7:0] period_timer_count;
	logic [1:0] sub_bits;
	logic       rollover;
	logic       tick;
	modport timer (output period_timer_count, output sub_bits, output rollover, output tick);
	modport user  (input period_timer_count, input sub_bits, input rollover, input tick);
endinterface

// file: rtl/ccpsp_period_timer.sv
// 8-bit period timer with prescaler; produces the 10-bit time base and rollover.
// Assumes run and sleep inputs are synchronous to clk.
`timescale 1ns/1ps
module ccpsp_period_timer (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Control.
	input  wire logic       timer_run,
	input  wire logic       sleep,
	input  wire logic [1:0] timer_prescale_sel,
	input  wire logic [7:0] period_limit,
	// Time base out.
	ccpsp_tb_if.timer       tb
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [1:0] sub_q;
	logic [1:0] sub_d;
	logic [7:0] ps_q;
	logic [7:0] ps_d;
	logic [7:0] ps_last;
	logic [7:0] ps_step;
	logic       step;
	logic       inc;
	logic       roll;

	// Prescale terminal count; the top two prescaler bits supply the sub-bits.
	always_comb begin
		case (timer_prescale_sel)
			ccpsp_pkg::PS_4:  ps_last = ccpsp_pkg::PS_LAST_4;
			ccpsp_pkg::PS_16: ps_last = ccpsp_pkg::PS_LAST_16;
			ccpsp_pkg::PS_64: ps_last = ccpsp_pkg::PS_LAST_64;
			default:          ps_last = ccpsp_pkg::PRESC_RST;
		endcase
	end

	// Counting; sleep freezes every state bit so counting resumes where it stopped.
	always_comb begin
		cnt_d = cnt_q;
		sub_d = sub_q;
		ps_d = ps_q;
		inc = 1'b0;
		roll = 1'b0;
		step = 1'b0;
		ps_step = ps_last >> ccpsp_pkg::SUB_W;
		if (timer_run && !sleep) begin
			if (timer_prescale_sel == ccpsp_pkg::PS_1) begin
				ps_d = ccpsp_pkg::PRESC_RST;
				sub_d = sub_q + 2'h1;
				inc = (sub_q == ccpsp_pkg::SUB_LAST);
				step = 1'b1;
			end else begin
				// The time base moves only when the low prescaler bits wrap.
				step = ((ps_q & ps_step) == ps_step);
				ps_d = (ps_q >= ps_last) ? ccpsp_pkg::PRESC_RST : ps_q + 8'h01;
				inc = (ps_q >= ps_last);
				case (timer_prescale_sel)
					ccpsp_pkg::PS_4:  sub_d = ps_d[ccpsp_pkg::PS_SHIFT_4 +: 2];
					ccpsp_pkg::PS_16: sub_d = ps_d[ccpsp_pkg::PS_SHIFT_16 +: 2];
					default:          sub_d = ps_d[ccpsp_pkg::PS_SHIFT_64 +: 2];
				endcase
			end
			if (inc) begin
				roll = (cnt_q == period_limit);
				cnt_d = roll ? ccpsp_pkg::TIMER_RST : cnt_q + 8'h01;
			end
		end
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= ccpsp_pkg::TIMER_RST;
			sub_q <= ccpsp_pkg::SUB_RST;
			ps_q <= ccpsp_pkg::PRESC_RST;
		end else begin
			cnt_q <= cnt_d;
			sub_q <= sub_d;
			ps_q <= ps_d;
		end
	end

	assign tb.period_timer_count = cnt_q;
	assign tb.sub_bits = sub_q;
	assign tb.rollover = roll;
	assign tb.tick = step; // Time base advances at the next edge.

	a_roll_clears: assert property (@(posedge clk) disable iff (sys_rst)
		roll |=> cnt_q == ccpsp_pkg::TIMER_RST) else $error("timer not cleared");
	a_sleep_holds: assert property (@(posedge clk) disable iff (sys_rst)
		sleep |=> $stable(cnt_q)) else $error("timer moved in sleep");
endmodule

// file: rtl/ccpsp_unit.sv
// Standard PWM unit top: duty double buffer, compare, pin driver and timer flag.
// Assumes all control inputs come from logic on clk; no register bus exists.
`timescale 1ns/1ps
module ccpsp_unit (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Power state.
	input  wire logic       sleep,
	// Software-side control.
	input  wire logic       unit_enable,
	input  wire logic       duty_align_bit,
	input  wire logic [7:0] duty_high,
	input  wire logic [7:0] duty_low,
	input  wire logic       duty_write,
	input  wire logic [7:0] period_reg,
	input  wire logic       period_write,
	input  wire logic [1:0] timer_prescale_sel,
	input  wire logic       timer_run,
	input  wire logic       pin_dir_write,
	input  wire logic       pin_dir_in,
	input  wire logic       flag_clear,
	// Status.
	output logic            output_level_bit,
	output logic            period_timer_flag,
	output logic [7:0]      period_timer_count,
	// Pin.
	output logic            pwm_out_pin,
	output logic            pwm_out_oe
);
	ccpsp_tb_if tbus ();

	logic [7:0] dh_q;
	logic [7:0] dh_d;
	logic [7:0] dl_q;
	logic [7:0] dl_d;
	logic       fmt_q;
	logic       fmt_d;
	logic [7:0] per_q;
	logic [7:0] per_d;
	logic [9:0] duty_buf_q;
	logic [9:0] duty_buf_d;
	logic       lvl_q;
	logic       lvl_d;
	logic       flag_q;
	logic       flag_d;
	logic       dir_in_q;
	logic       dir_in_d;
	logic [7:0] cnt_q;
	logic [9:0] tbase;
	logic [9:0] tbase_next;
	logic [9:0] duty_sw;

	// Assemble the 10-bit duty from the two registers per the alignment bit.
	function automatic logic [9:0] duty_join(input logic fmt, input logic [7:0] hi,
		input logic [7:0] lo);
		if (fmt == ccpsp_pkg::CCPSP_ALIGN_LEFT)
			duty_join = {hi, lo[ccpsp_pkg::LEFT_LOW_HI:ccpsp_pkg::LEFT_LOW_LO]};
		else
			duty_join = {hi[ccpsp_pkg::RIGHT_HIGH_HI:ccpsp_pkg::RIGHT_HIGH_LO], lo};
	endfunction

	// The timer lives in its own module; the postscaler is not modelled because it
	// never feeds the PWM period.
	ccpsp_period_timer u_timer (
		.clk                (clk),
		.sys_rst            (sys_rst),
		.timer_run          (timer_run),
		.sleep              (sleep),
		.timer_prescale_sel (timer_prescale_sel),
		.period_limit       (per_q),
		.tb                 (tbus.timer)
	);

	assign duty_sw = duty_join(fmt_q, dh_q, dl_q);
	assign tbase = {tbus.period_timer_count, tbus.sub_bits};
	// Comparing the next time base lets the pin fall exactly as the match starts.
	assign tbase_next = tbase + 10'h001;

	// Software-visible registers; writes are accepted any time, even in sleep.
	always_comb begin
		dh_d = dh_q;
		dl_d = dl_q;
		fmt_d = duty_align_bit;
		per_d = per_q;
		dir_in_d = dir_in_q;
		if (duty_write) begin
			dh_d = duty_high;
			dl_d = duty_low;
		end
		if (period_write)
			per_d = period_reg;
		if (pin_dir_write)
			dir_in_d = pin_dir_in;
	end

	// Output logic: buffer loads at rollover, pin set there unless the new duty is zero, compare clears the pin.
	// The compare only sees the buffered value, so a mid-period write cannot glitch.
	always_comb begin
		duty_buf_d = duty_buf_q;
		lvl_d = lvl_q;
		if (!unit_enable) begin
			lvl_d = 1'b0;
		end else if (tbus.tick) begin
			if (tbus.rollover) begin
				duty_buf_d = duty_sw;
				lvl_d = (duty_sw != ccpsp_pkg::DUTY_RST);
			end else if (tbase_next == duty_buf_q) begin
				lvl_d = 1'b0;
			end
		end
	end

	// Timer flag: hardware set wins over a software clear in the same cycle.
	always_comb begin
		flag_d = flag_q;
		if (flag_clear)
			flag_d = 1'b0;
		if (tbus.rollover)
			flag_d = 1'b1;
	end

	// State registers; reset returns defaults and turns the pin to input.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dh_q <= ccpsp_pkg::DUTY_REG_RST;
			dl_q <= ccpsp_pkg::DUTY_REG_RST;
			fmt_q <= 1'b0;
			per_q <= ccpsp_pkg::PERIOD_RST;
			duty_buf_q <= ccpsp_pkg::DUTY_RST;
			lvl_q <= 1'b0;
			flag_q <= 1'b0;
			dir_in_q <= 1'b1;
			cnt_q <= ccpsp_pkg::TIMER_RST;
		end else begin
			dh_q <= dh_d;
			dl_q <= dl_d;
			fmt_q <= fmt_d;
			per_q <= per_d;
			duty_buf_q <= duty_buf_d;
			lvl_q <= lvl_d;
			flag_q <= flag_d;
			dir_in_q <= dir_in_d;
			cnt_q <= tbus.period_timer_count;
		end
	end

	// Outputs straight from flip-flops.
	assign pwm_out_pin = lvl_q;
	assign pwm_out_oe = !dir_in_q;
	assign output_level_bit = lvl_q;
	assign period_timer_flag = flag_q;
	assign period_timer_count = cnt_q;

	a_pin_set_roll: assert property (@(posedge clk) disable iff (sys_rst)
		unit_enable && tbus.tick && tbus.rollover && duty_sw != ccpsp_pkg::DUTY_RST
		|=> lvl_q) else $error("pin not set at rollover");
	a_zero_duty_low: assert property (@(posedge clk) disable iff (sys_rst)
		tbus.rollover && duty_sw == ccpsp_pkg::DUTY_RST |=> !lvl_q)
		else $error("pin set with zero duty");
	a_buf_loaded: assert property (@(posedge clk) disable iff (sys_rst)
		unit_enable && tbus.tick && tbus.rollover |=> duty_buf_q == $past(duty_sw))
		else $error("duty buffer not loaded");
	a_buf_held: assert property (@(posedge clk) disable iff (sys_rst)
		!tbus.rollover |=> $stable(duty_buf_q)) else $error("buffer changed mid period");
	a_match_clears: assert property (@(posedge clk) disable iff (sys_rst)
		tbus.tick && !tbus.rollover && tbase_next == duty_buf_q |=> !lvl_q)
		else $error("pin not cleared on match");
	a_no_rise_mid: assert property (@(posedge clk) disable iff (sys_rst)
		!tbus.rollover && !lvl_q |=> !lvl_q) else $error("pin rose mid period");
	a_flag_sets: assert property (@(posedge clk) disable iff (sys_rst)
		tbus.rollover |=> flag_q) else $error("timer flag not set");
	a_sleep_freeze: assert property (@(posedge clk) disable iff (sys_rst)
		sleep && unit_enable |=> $stable(lvl_q) && $stable(duty_buf_q))
		else $error("state moved in sleep");
	a_level_bit: assert property (@(posedge clk) disable iff (sys_rst)
		output_level_bit == pwm_out_pin) else $error("level bit mismatch");
	a_reset_input: assert property (@(posedge clk) sys_rst |=> !pwm_out_oe && !pwm_out_pin)
		else $error("pin driven after reset");

	c_rollover: cover property (@(posedge clk) disable iff (sys_rst) tbus.rollover && lvl_d);
	c_match: cover property (@(posedge clk) disable iff (sys_rst) lvl_q ##1 !lvl_q);
	c_sleep: cover property (@(posedge clk) disable iff (sys_rst) sleep && lvl_q);
	c_flag_race: cover property (@(posedge clk) disable iff (sys_rst)
		flag_clear && tbus.rollover);
endmodule

// file: verif/ccpsp_load_model.sv
// Load model on the PWM pin: measures pulse width and period in clock cycles.
// Assumes the load pulls the line low while the unit's driver is off.
`timescale 1ns/1ps
module ccpsp_load_model (
	// Clock.
	input  wire logic        clk,
	// Pin.
	input  wire logic        pwm_out_pin,
	input  wire logic        pwm_out_oe,
	// Measurements.
	output logic             line_level,
	output logic             rise_seen,
	output logic [15:0]      high_len,
	output logic [15:0]      period_len
);
	logic        prev_q = 1'b0;
	logic [15:0] hi_cnt_q;
	logic [15:0] per_cnt_q;

	// The pull-down wins while the driver is off, so a released pin never shows a stale level.
	assign line_level = pwm_out_oe ? pwm_out_pin : 1'b0;
	assign rise_seen  = line_level & ~prev_q;

	// Counts restart at each rise; a fall latches the width, the next rise the period.
	always_ff @(posedge clk) begin
		prev_q <= line_level;
		per_cnt_q <= rise_seen ? 16'h0001 : per_cnt_q + 16'h0001;
		hi_cnt_q <= rise_seen ? 16'h0001 : hi_cnt_q + 16'h0001;
		if (rise_seen) period_len <= per_cnt_q;
		if (~line_level & prev_q) high_len <= hi_cnt_q;
	end
endmodule

// file: verif/test_ccp_standard_pwm.sv
// Testbench for the standard PWM unit: setup, duty, alignment, prescale, sleep and reset.
// Assumes the load model on the pin and a 100 MHz clock.
`timescale 1ns/1ps
module test_ccp_standard_pwm;
	logic        clk = 1'b0;
	logic        sys_rst, sleep, unit_enable, duty_align_bit, duty_write, period_write;
	logic        timer_run, pin_dir_write, pin_dir_in, flag_clear;
	logic [7:0]  duty_high, duty_low, period_reg, keep_count;
	logic [1:0]  timer_prescale_sel;
	logic        output_level_bit, period_timer_flag, pwm_out_pin, pwm_out_oe;
	logic [7:0]  period_timer_count;
	logic        line_level, rise_seen, keep_level;
	logic [15:0] high_len, period_len;
	int          fail_count = 0;
	int          samples_checked = 0;

	ccpsp_unit i_ccpsp_unit (.clk, .sys_rst, .sleep, .unit_enable, .duty_align_bit,
		.duty_high, .duty_low, .duty_write, .period_reg, .period_write, .timer_prescale_sel,
		.timer_run, .pin_dir_write, .pin_dir_in, .flag_clear, .output_level_bit,
		.period_timer_flag, .period_timer_count, .pwm_out_pin, .pwm_out_oe);
	ccpsp_load_model i_ccpsp_load_model (.clk, .pwm_out_pin, .pwm_out_oe, .line_level,
		.rise_seen, .high_len, .period_len);

	// Free-running 10 ns clock.
	always #5 clk = ~clk;

	// Inputs move 1 ns after the edge so no race with the design's sampling.
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Control writes are single-cycle strobes, as the unit expects.
	task automatic set_duty(input logic al, input logic [7:0] hi, input logic [7:0] lo);
		duty_align_bit = al;
		duty_high = hi;
		duty_low = lo;
		duty_write = 1'b1;
		step(1);
		duty_write = 1'b0;
	endtask
	task automatic set_period(input logic [7:0] p);
		period_reg = p;
		period_write = 1'b1;
		step(1);
		period_write = 1'b0;
	endtask
	task automatic set_dir(input logic d);
		pin_dir_in = d;
		pin_dir_write = 1'b1;
		step(1);
		pin_dir_write = 1'b0;
	endtask
	task automatic clear_flag();
		flag_clear = 1'b1;
		step(1);
		flag_clear = 1'b0;
	endtask
	// Bounded wait, so a dead pin ends as a mismatch rather than a hang.
	task automatic wait_rise();
		for (int i = 0; i < 3000 && rise_seen !== 1'b1; i++) step(1);
		check(rise_seen, 1'b1);
		step(1);
	endtask

	// Watchdog: the whole sequence needs well under 10,000 cycles.
	initial begin
		#300us;
		fail_count++;
		tally_and_finish();
	end

	// Main sequence.
	initial begin
		{sleep, unit_enable, duty_align_bit, duty_write, period_write} = 5'h00;
		{timer_run, pin_dir_write, pin_dir_in, flag_clear} = 4'h0;
		{duty_high, duty_low, period_reg, timer_prescale_sel} = 26'h0000000;
		sys_rst = 1'b1;
		step(3);
		sys_rst = 1'b0;
		check({pwm_out_pin, pwm_out_oe, period_timer_flag}, 3'h0);
		check(period_timer_count, ccpsp_pkg::TIMER_RST);
		$display("test reset done");
		// Setup in the advised order, driver off until the first overflow.
		set_dir(1'b1);
		set_period(8'h03);
		unit_enable = 1'b1;
		set_duty(ccpsp_pkg::CCPSP_ALIGN_RIGHT, 8'h00, 8'h05);
		clear_flag();
		timer_prescale_sel = ccpsp_pkg::PS_1;
		timer_run = 1'b1;
		for (int i = 0; i < 3000 && period_timer_flag !== 1'b1; i++) step(1);
		check(period_timer_flag, 1'b1);
		set_dir(1'b0);
		repeat (3) wait_rise();
		check(period_len, 16'h0010);
		check(high_len, 16'h0005);
		repeat (16) begin
			check(period_timer_count > 8'h03, 1'b0);
			step(1);
		end
		wait_rise();
		clear_flag();
		check(period_timer_flag, 1'b0);
		wait_rise();
		check(period_timer_flag, 1'b1);
		$display("test setup and period done");
		// Write mid-period: old duty finishes, then left-aligned 9 applies.
		set_duty(ccpsp_pkg::CCPSP_ALIGN_LEFT, 8'h02, 8'h40);
		wait_rise();
		check(high_len, 16'h0005);
		wait_rise();
		check(high_len, 16'h0009);
		$display("test duty buffering done");
		set_duty(ccpsp_pkg::CCPSP_ALIGN_RIGHT, 8'h00, 8'h00);
		step(40);
		repeat (4) begin
			step(8);
			check({line_level, output_level_bit}, 2'h0);
		end
		set_duty(ccpsp_pkg::CCPSP_ALIGN_RIGHT, 8'h00, 8'h14);
		wait_rise();
		repeat (4) begin
			step(8);
			check({line_level, output_level_bit}, 2'h3);
		end
		$display("test zero and overlong duty done");
		// Sleep freezes the timer and the pin mid-period.
		set_duty(ccpsp_pkg::CCPSP_ALIGN_RIGHT, 8'h00, 8'h05);
		repeat (2) wait_rise();
		sleep = 1'b1;
		step(2);
		keep_count = period_timer_count;
		keep_level = line_level;
		step(20);
		check(period_timer_count, keep_count);
		check(line_level, keep_level);
		sleep = 1'b0;
		repeat (3) wait_rise();
		check(period_len, 16'h0010);
		$display("test sleep done");
		// Every prescale setting: period 8N and width 3N clocks.
		set_period(8'h01);
		set_duty(ccpsp_pkg::CCPSP_ALIGN_RIGHT, 8'h00, 8'h03);
		for (int s = 0; s < 4; s++) begin
			timer_prescale_sel = s[1:0];
			repeat (3) wait_rise();
			check(period_len, 16'h0008 << (2 * s));
			check(high_len, 16'h0003 << (2 * s));
		end
		$display("test prescale done");
		unit_enable = 1'b0;
		step(3);
		check({output_level_bit, pwm_out_pin}, 2'h0);
		sys_rst = 1'b1;
		step(1);
		sys_rst = 1'b0;
		check({pwm_out_oe, period_timer_flag, period_timer_count}, 10'h000);
		$display("test disable and reset done");
		tally_and_finish();
	end
endmodule
